// ==== src/ccp_control_port.sv ====
// Codec control port: SPI or I2C slave onto a paged 8-bit register map
`timescale 1ns/1ps
`default_nettype none

module ccp_control_port
  import ccp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic     clk,
  input  wire logic     resetn,
  input  wire logic     clk_en,
  // Protocol select pin
  input  wire logic     protocol_select,
  // Multifunction pins
  input  wire logic     multifunction_pin_a,
  input  wire logic     multifunction_pin_b,
  output var  logic     multifunction_pin_c,
  output var  logic     multifunction_pin_c_oe,
  input  wire logic     multifunction_pin_d,
  // I2C pins, open drain
  input  wire logic     i2c_scl,
  input  wire logic     i2c_sda_in,
  output var  logic     i2c_sda_out,
  output var  logic     i2c_sda_oe,
  // Register file side
  output var  logic     reg_wr,
  output var  ccp_acc_s reg_acc,
  input  wire logic [7:0] reg_rdata,
  output var  logic     page_select
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] sync_q;
  logic [SYNC_W-1:0] pins;

  assign pins = {1'b0, i2c_sda_in, i2c_scl, multifunction_pin_d,
                 multifunction_pin_b, multifunction_pin_a, protocol_select};

  // Two flops per pin, third stage only for edge finding
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1  <= '0;
      sync2  <= '0;
      sync_q <= '0;
    end else if (clk_en) begin
      sync1  <= pins;
      sync2  <= sync1;
      sync_q <= sync2;
    end
  end

  logic mode_spi;
  logic ss_n;
  logic sclk;
  logic mosi;
  logic scl;
  logic sda;
  logic ss_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic scl_rise;
  logic scl_fall;
  logic i2c_start;
  logic i2c_stop;

  assign mode_spi  = sync2[LN_SEL];
  assign ss_n      = sync2[LN_PA];
  assign sclk      = sync2[LN_PB];
  assign mosi      = sync2[LN_PD];
  assign scl       = sync2[LN_SCL];
  assign sda       = sync2[LN_SDA];
  assign ss_fall   = sync_q[LN_PA] & ~ss_n;
  assign sclk_rise = ~sync_q[LN_PB] & sclk;
  assign sclk_fall = sync_q[LN_PB] & ~sclk;
  assign scl_rise  = ~sync_q[LN_SCL] & scl;
  assign scl_fall  = sync_q[LN_SCL] & ~scl;
  // Data moving while the clock is high marks start or stop
  assign i2c_start = scl & sync_q[LN_SCL] & sync_q[LN_SDA] & ~sda;
  assign i2c_stop  = scl & sync_q[LN_SCL] & ~sync_q[LN_SDA] & sda;

  ////////////////////////////////////////////////////////////////////////////
  // Read data source: page register is local, the rest comes from the file

  logic [7:0] fetch_byte;

  always_comb begin
    if (reg_acc.addr == PAGE_SEL_ADDR) begin
      fetch_byte = 8'h00;
      fetch_byte[PAGE_BIT] = page_select;
    end else begin
      fetch_byte = reg_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SPI slave, CPOL 0 / CPHA 1: drive on rising, sample on falling edge

  logic [2:0] spi_cnt;
  logic [7:0] spi_rx;
  logic [6:0] spi_tx;
  logic       spi_cmd_done;
  logic       spi_rd;
  logic [7:0] next_spi_rx;
  logic       spi_active;
  logic       spi_byte_end;

  assign next_spi_rx  = {spi_rx[6:0], mosi};
  assign spi_active   = mode_spi & ~ss_n;
  assign spi_byte_end = spi_active & ~ss_fall & sclk_fall & (spi_cnt == LAST_BIT);

  // Receive side; a select fall always restarts with a command byte
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      spi_cnt      <= '0;
      spi_rx       <= '0;
      spi_cmd_done <= 1'b0;
      spi_rd       <= 1'b0;
    end else if (clk_en) begin
      if (!spi_active || ss_fall) begin
        spi_cnt      <= '0;
        spi_cmd_done <= 1'b0;
      end else if (sclk_fall) begin
        spi_rx  <= next_spi_rx;
        spi_cnt <= spi_cnt + 3'h1;
        if (spi_cnt == LAST_BIT && !spi_cmd_done) begin
          spi_cmd_done <= 1'b1;
          spi_rd       <= next_spi_rx[CMD_RW_BIT];
        end
      end
    end
  end

  // Transmit side; the output floats while the device is not selected
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      multifunction_pin_c    <= 1'b0;
      multifunction_pin_c_oe <= 1'b0;
      spi_tx                 <= '0;
    end else if (clk_en) begin
      if (!spi_active || ss_fall) begin
        multifunction_pin_c_oe <= 1'b0;
        multifunction_pin_c    <= 1'b0;
      end else if (sclk_rise) begin
        multifunction_pin_c_oe <= 1'b1;
        if (spi_cmd_done && spi_rd) begin
          if (spi_cnt == 3'h0) begin
            {multifunction_pin_c, spi_tx} <= fetch_byte;
          end else begin
            {multifunction_pin_c, spi_tx} <= {spi_tx, 1'b0};
          end
        end else begin
          multifunction_pin_c <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // I2C slave: bit count 0..7 data, 8 acknowledge slot, 9 slot done

  ccp_i2c_e   i2c_state;
  logic [3:0] i2c_cnt;
  logic [7:0] i2c_rx;
  logic [6:0] i2c_tx;
  logic       i2c_tx_go;
  logic       i2c_mack;
  logic [6:0] i2c_own_addr;
  logic       i2c_hit;
  logic       i2c_byte_end;
  logic       i2c_on;

  assign i2c_on       = ~mode_spi;
  // Low address bits follow the straps: pin b upper, pin a lower
  assign i2c_own_addr = {I2C_ADDR_HI, sync2[LN_PB], sync2[LN_PA]};
  assign i2c_hit      = (i2c_rx[7:1] == i2c_own_addr) || (i2c_rx == GENERAL_CALL);
  assign i2c_byte_end = i2c_on & ~i2c_start & ~i2c_stop & scl_fall & (i2c_cnt == ACK_SLOT);

  // Byte engine and state walk
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      i2c_state <= I2C_IDLE;
      i2c_cnt   <= '0;
      i2c_rx    <= '0;
      i2c_tx_go <= 1'b0;
      i2c_mack  <= 1'b0;
    end else if (clk_en) begin
      if (!i2c_on || i2c_stop) begin
        i2c_state <= I2C_IDLE;
        i2c_cnt   <= '0;
        i2c_tx_go <= 1'b0;
      end else if (i2c_start) begin
        i2c_state <= I2C_ADDR;
        i2c_cnt   <= '0;
        i2c_tx_go <= 1'b0;
      end else if (i2c_state != I2C_IDLE) begin
        if (scl_rise) begin
          if (i2c_cnt < ACK_SLOT) begin
            i2c_rx  <= {i2c_rx[6:0], sda};
            i2c_cnt <= i2c_cnt + 4'h1;
          end else if (i2c_cnt == ACK_SLOT) begin
            i2c_mack <= ~sda;
            i2c_cnt  <= ACK_DONE;
          end
        end else if (scl_fall && i2c_cnt == ACK_SLOT) begin
          case (i2c_state)
            I2C_ADDR: begin
              if (!i2c_hit) begin
                i2c_state <= I2C_IDLE;
              end else if (i2c_rx[CMD_RW_BIT]) begin
                i2c_state <= I2C_RDATA;
                i2c_tx_go <= 1'b1;
              end else begin
                i2c_state <= I2C_REGA;
              end
            end
            I2C_REGA:  i2c_state <= I2C_WDATA;
            I2C_WDATA: i2c_state <= I2C_WDATA;
            I2C_RDATA: i2c_tx_go <= 1'b0;
            default:   i2c_state <= I2C_IDLE;
          endcase
        end else if (scl_fall && i2c_cnt == ACK_DONE) begin
          i2c_cnt <= '0;
          if (i2c_state == I2C_RDATA && !i2c_tx_go && !i2c_mack) begin
            i2c_state <= I2C_IDLE;
          end
          i2c_tx_go <= 1'b0;
        end
      end
    end
  end

  // Open-drain data driver: only ever pulls low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      i2c_sda_oe  <= 1'b0;
      i2c_sda_out <= 1'b0;
      i2c_tx      <= '0;
    end else if (clk_en) begin
      i2c_sda_out <= 1'b0;
      if (!i2c_on || i2c_start || i2c_stop) begin
        i2c_sda_oe <= 1'b0;
      end else if (scl_fall) begin
        if (i2c_cnt == ACK_SLOT) begin
          // Acknowledge received bytes; release to hear the master on reads
          i2c_sda_oe <= (i2c_state == I2C_ADDR) ? i2c_hit :
                        (i2c_state == I2C_REGA || i2c_state == I2C_WDATA);
        end else if (i2c_cnt == ACK_DONE) begin
          if (i2c_state == I2C_RDATA && (i2c_tx_go || i2c_mack)) begin
            i2c_sda_oe <= ~fetch_byte[7];
            i2c_tx     <= fetch_byte[6:0];
          end else begin
            i2c_sda_oe <= 1'b0;
          end
        end else if (i2c_state == I2C_RDATA && i2c_cnt < ACK_SLOT) begin
          i2c_sda_oe <= ~i2c_tx[6];
          i2c_tx     <= {i2c_tx[5:0], 1'b0};
        end else begin
          i2c_sda_oe <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register pointer, write strobe and page control shared by both ports

  logic       ev_load;
  logic       ev_write;
  logic       ev_inc;
  logic [6:0] ev_addr;
  logic [7:0] ev_data;
  logic       wr_step;

  // Pick the live protocol's events; only one can be active at a time
  always_comb begin
    ev_load  = 1'b0;
    ev_write = 1'b0;
    ev_inc   = 1'b0;
    ev_addr  = '0;
    ev_data  = '0;
    if (spi_byte_end) begin
      if (!spi_cmd_done) begin
        ev_load = 1'b1;
        ev_addr = next_spi_rx[CMD_ADDR_MSB:CMD_ADDR_LSB];
      end else begin
        ev_write = ~spi_rd;
        ev_data  = next_spi_rx;
        ev_inc   = 1'b1;
      end
    end else if (i2c_byte_end) begin
      case (i2c_state)
        I2C_REGA: begin
          ev_load = 1'b1;
          ev_addr = i2c_rx[6:0];
        end
        I2C_WDATA: begin
          ev_write = 1'b1;
          ev_data  = i2c_rx;
          ev_inc   = 1'b1;
        end
        I2C_RDATA: ev_inc = 1'b1;
        default:   ev_inc = 1'b0;
      endcase
    end
  end

  // Pointer and write strobe; the pointer also addresses register reads.
  // The step after a write waits a cycle so the strobe keeps its own address.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_wr  <= 1'b0;
      reg_acc <= '0;
      wr_step <= 1'b0;
    end else if (clk_en) begin
      reg_wr  <= 1'b0;
      wr_step <= ev_write;
      if (ev_load) begin
        reg_acc.addr <= ev_addr;
      end else if (ev_write) begin
        // Page register stays local; others go out with the active page
        reg_wr       <= (reg_acc.addr != PAGE_SEL_ADDR);
        reg_acc.data <= ev_data;
        reg_acc.page <= page_select;
      end else if (wr_step) begin
        reg_acc.addr <= reg_acc.addr + 7'h01;
      end else if (ev_inc) begin
        reg_acc.addr <= reg_acc.addr + 7'h01;
      end
      if (!ev_write) begin
        reg_acc.page <= page_select;
      end
    end
  end

  // Active page persists until the next page register write
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      page_select <= PAGE_RESET;
    end else if (clk_en) begin
      if (ev_write && reg_acc.addr == PAGE_SEL_ADDR) begin
        page_select <= ev_data[PAGE_BIT];
      end
    end
  end

endmodule : ccp_control_port

`default_nettype wire

// ==== src/ccp_pkg.sv ====
// Constants and types for the codec control port
package ccp_pkg;

  // Byte framing
  localparam int unsigned BYTE_BITS     = 8;
  localparam logic [2:0]  LAST_BIT      = 3'h7;
  localparam logic [3:0]  ACK_SLOT      = 4'h8;
  localparam logic [3:0]  ACK_DONE      = 4'h9;

  // Register map
  localparam logic [6:0]  PAGE_SEL_ADDR = 7'h00;
  localparam logic        PAGE_RESET    = 1'h0;
  localparam int unsigned PAGE_BIT      = 0;

  // Command byte layout
  localparam int unsigned CMD_ADDR_MSB  = 7;
  localparam int unsigned CMD_ADDR_LSB  = 1;
  localparam int unsigned CMD_RW_BIT    = 0;

  // I2C addressing
  localparam logic [4:0]  I2C_ADDR_HI   = 5'h06;
  localparam logic [7:0]  GENERAL_CALL  = 8'h00;

  // Synchroniser lane positions
  localparam int unsigned SYNC_W        = 7;
  localparam int unsigned LN_SEL        = 0;
  localparam int unsigned LN_PA         = 1;
  localparam int unsigned LN_PB         = 2;
  localparam int unsigned LN_PD         = 3;
  localparam int unsigned LN_SCL        = 4;
  localparam int unsigned LN_SDA        = 5;
  localparam int unsigned LN_SPARE      = 6;

  // Register access carried to the register file
  typedef struct packed {
    logic       page;
    logic [6:0] addr;
    logic [7:0] data;
  } ccp_acc_s;

  // I2C slave states, one-hot
  typedef enum logic [4:0] {
    I2C_IDLE  = 5'b00001,
    I2C_ADDR  = 5'b00010,
    I2C_REGA  = 5'b00100,
    I2C_WDATA = 5'b01000,
    I2C_RDATA = 5'b10000
  } ccp_i2c_e;

endpackage : ccp_pkg

// ==== verif/ccp_host_model.sv ====
// Host processor model: four-wire master and open-drain two-wire master
`timescale 1ns/1ps
`default_nettype none

module ccp_host_model (
  // Pacing clock
  input  wire logic clk,
  // Four-wire lines
  output var  logic ss_n,
  output var  logic sclk,
  output var  logic mosi,
  input  wire logic miso,
  // Two-wire lines, SDA only ever pulled low
  output var  logic scl,
  output var  logic sda_low,
  input  wire logic sda
);
  initial begin
    ss_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Pins move on falling edges only, away from the sampling edge
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk

  // Select changes between frames; MOSI toggles so idle data is never stale
  task automatic spi_sel(input logic on);
    wait_clk(4);
    ss_n = !on;
    mosi = !mosi;
    wait_clk(4);
  endtask : spi_sel

  // Both sides drive on the rise, sample on the fall, MSB first
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      wait_clk(4);
      sclk = 1'b1;
      mosi = tx[i];
      wait_clk(4);
      rx[i] = miso;
      sclk = 1'b0;
    end
  endtask : spi_byte

  // START; from an active bus this is a repeated START
  task automatic i2c_start();
    sda_low = 1'b0;
    wait_clk(5);
    scl = 1'b1;
    wait_clk(4);
    sda_low = 1'b1;
    wait_clk(4);
    scl = 1'b0;
  endtask : i2c_start

  task automatic i2c_stop();
    sda_low = 1'b1;
    wait_clk(5);
    scl = 1'b1;
    wait_clk(4);
    sda_low = 1'b0;
    wait_clk(4);
  endtask : i2c_stop

  // Eight bits then the ack clock; tx of all ones leaves SDA to the device
  task automatic i2c_byte(input logic [7:0] tx, input logic mack,
                          output logic [7:0] rx, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      wait_clk(2);
      sda_low = (i == 0) ? mack : !tx[7];
      tx = tx << 1;
      wait_clk(3);
      scl = 1'b1;
      wait_clk(3);
      if (i == 0) ack = !sda;
      else rx = {rx[6:0], sda};
      scl = 1'b0;
    end
  endtask : i2c_byte
endmodule : ccp_host_model
`default_nettype wire

// ==== verif/ccp_properties.sv ====
// Concurrent checks on the control port pins and register file side
`timescale 1ns/1ps
`default_nettype none

module ccp_properties
  import ccp_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       clk_en,
  // Pins
  input wire logic       protocol_select,
  input wire logic       multifunction_pin_a,
  input wire logic       multifunction_pin_b,
  input wire logic       multifunction_pin_c,
  input wire logic       multifunction_pin_c_oe,
  input wire logic       multifunction_pin_d,
  input wire logic       i2c_scl,
  input wire logic       i2c_sda_in,
  input wire logic       i2c_sda_out,
  input wire logic       i2c_sda_oe,
  // Register file side
  input wire logic       reg_wr,
  input wire ccp_acc_s   reg_acc,
  input wire logic [7:0] reg_rdata,
  input wire logic       page_select
);
  logic [6:0] last_addr;

  // Address of the last write; the pointer must step from it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) last_addr <= 7'h00;
    else if (reg_wr) last_addr <= reg_acc.addr;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_sda_never_high: assert property (i2c_sda_out == 1'b0)
    else $error("sda driven high");
  chk_wr_not_page: assert property (reg_wr |-> reg_acc.addr != PAGE_SEL_ADDR)
    else $error("write strobe for page register");
  chk_wr_single: assert property (reg_wr |=> !reg_wr)
    else $error("write strobe longer than one cycle");
  chk_addr_step: assert property (reg_wr |=> ##[0:3] reg_acc.addr == last_addr + 7'h01)
    else $error("pointer did not step after write");
  // Sync and register stages allow five edges before the line must drop
  chk_miso_idle: assert property (multifunction_pin_a [*6] |-> !multifunction_pin_c_oe)
    else $error("data out driven while deselected");
  chk_miso_in_i2c: assert property (!protocol_select [*6] |-> !multifunction_pin_c_oe)
    else $error("data out driven in two-wire mode");
  chk_sda_in_spi: assert property (protocol_select [*6] |-> !i2c_sda_oe)
    else $error("sda pulled in four-wire mode");
  chk_page_reset: assert property ($rose(resetn) |-> !page_select)
    else $error("page not zero after reset");
  chk_page_cause: assert property (
    $changed(page_select) |-> $past(reg_acc.addr) == PAGE_SEL_ADDR)
    else $error("page moved without page register access");

  cov_write: cover property (reg_wr);
  cov_ack: cover property ($rose(i2c_sda_oe));
  cov_page: cover property ($rose(page_select));
endmodule : ccp_properties

bind ccp_control_port ccp_properties u_chk (
  .clk(clk), .resetn(resetn), .clk_en(clk_en), .protocol_select(protocol_select),
  .multifunction_pin_a(multifunction_pin_a), .multifunction_pin_b(multifunction_pin_b),
  .multifunction_pin_c(multifunction_pin_c), .multifunction_pin_c_oe(multifunction_pin_c_oe),
  .multifunction_pin_d(multifunction_pin_d), .i2c_scl(i2c_scl), .i2c_sda_in(i2c_sda_in),
  .i2c_sda_out(i2c_sda_out), .i2c_sda_oe(i2c_sda_oe), .reg_wr(reg_wr), .reg_acc(reg_acc),
  .reg_rdata(reg_rdata), .page_select(page_select)
);
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the codec control port
`timescale 1ns/1ps
`default_nettype none

module tb;
  import ccp_pkg::*;
  logic       clk, resetn, clk_en, protocol_select, strap_a, strap_b, ack;
  logic       ss_n, sclk, mosi, scl, sda_low, miso_c, miso_oe, miso_last;
  logic       sda_out, sda_oe, reg_wr, page_select;
  logic [7:0] d, n, rx, reg_rdata, mem [2][128];
  logic [7:0] wr_cnt = 8'h00;
  ccp_acc_s   reg_acc;
  int         n_fail, checks_done;
  wire        sda = !(sda_low || (sda_oe && !sda_out));
  wire        miso = miso_oe ? miso_c : !miso_last;
  wire        pin_a = protocol_select ? ss_n : strap_a;
  wire        pin_b = protocol_select ? sclk : strap_b;
  localparam ccp_acc_s ROWS [4] = '{'{1'b0, 7'h01, 8'ha5}, '{1'b1, 7'h7f, 8'h3c},
                                    '{1'b1, 7'h11, 8'hff}, '{1'b0, 7'h40, 8'h00}};

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Register file: combinational read, written on the strobe
  assign reg_rdata = mem[reg_acc.page][reg_acc.addr];
  always @(posedge clk) begin
    if (reg_wr) mem[reg_acc.page][reg_acc.addr] <= reg_acc.data;
    if (reg_wr) wr_cnt <= wr_cnt + 8'h01;
    if (miso_oe) miso_last <= miso_c;
  end

  ccp_control_port u_dut (
    .clk(clk), .resetn(resetn), .clk_en(clk_en), .protocol_select(protocol_select),
    .multifunction_pin_a(pin_a), .multifunction_pin_b(pin_b),
    .multifunction_pin_c(miso_c), .multifunction_pin_c_oe(miso_oe),
    .multifunction_pin_d(mosi), .i2c_scl(scl), .i2c_sda_in(sda), .i2c_sda_out(sda_out),
    .i2c_sda_oe(sda_oe), .reg_wr(reg_wr), .reg_acc(reg_acc), .reg_rdata(reg_rdata),
    .page_select(page_select)
  );
  ccp_host_model u_host (
    .clk(clk), .ss_n(ss_n), .sclk(sclk), .mosi(mosi), .miso(miso),
    .scl(scl), .sda_low(sda_low), .sda(sda)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task automatic spi_write(input logic [6:0] a, input logic [7:0] v);
    u_host.spi_sel(1'b1);
    u_host.spi_byte({a, 1'b0}, rx);
    u_host.spi_byte(v, rx);
    u_host.spi_sel(1'b0);
  endtask : spi_write

  // Bytes sent during a read are noise and must not be stored
  task automatic spi_read(input logic [6:0] a, output logic [7:0] v);
    u_host.spi_sel(1'b1);
    u_host.spi_byte({a, 1'b1}, rx);
    u_host.spi_byte(8'h99, v);
    u_host.spi_sel(1'b0);
  endtask : spi_read

  task automatic i2c_tx(input logic [7:0] b, input logic exp_ack);
    u_host.i2c_byte(b, 1'b0, rx, ack);
    check({7'h00, ack}, {7'h00, exp_ack});
  endtask : i2c_tx

  // Hang guard, several times the expected run length
  initial begin
    #3000000;
    n_fail++;
    complete_run();
  end

  initial begin
    resetn = 1'b0;
    clk_en = 1'b1;
    protocol_select = 1'b1;
    {strap_b, strap_a} = 2'h0;
    for (int k = 0; k < 256; k++) mem[k / 128][k % 128] = k[7:0];
    repeat (3) @(negedge clk);
    check({4'h0, page_select, reg_wr, miso_oe, sda_oe}, 8'h00);
    resetn = 1'b1;
    u_host.wait_clk(6);
    // Ordinary accesses: select page, write, read back
    foreach (ROWS[i]) begin
      spi_write(PAGE_SEL_ADDR, {7'h00, ROWS[i].page});
      spi_read(PAGE_SEL_ADDR, d);
      check(d, {7'h00, ROWS[i].page});
      spi_write(ROWS[i].addr, ROWS[i].data);
      check(mem[ROWS[i].page][ROWS[i].addr], ROWS[i].data);
      n = wr_cnt;
      spi_read(ROWS[i].addr, d);
      check(d, ROWS[i].data);
      check(wr_cnt - n, 8'h00);
    end
    spi_read(7'h11, d);
    check(d, 8'h11);
    // Frozen port: a whole write frame must leave no trace
    n = wr_cnt;
    clk_en = 1'b0;
    spi_write(7'h05, 8'h77);
    clk_en = 1'b1;
    u_host.wait_clk(4);
    check(wr_cnt - n, 8'h00);
    check(mem[0][7'h05], 8'h05);
    // Driver-type writes: single frames, select high well over 6.25 us
    spi_write(7'h50, 8'h12);
    u_host.wait_clk(64);
    spi_write(7'h51, 8'h34);
    check(mem[0][7'h50], 8'h12);
    check(mem[0][7'h51], 8'h34);
    // Burst near the end of page 1, 0x7c to 0x7e, then burst read
    spi_write(PAGE_SEL_ADDR, 8'h01);
    u_host.spi_sel(1'b1);
    u_host.spi_byte({7'h7c, 1'b0}, rx);
    for (int k = 0; k < 3; k++) u_host.spi_byte(8'h31 + k[7:0], rx);
    u_host.spi_sel(1'b0);
    check(mem[1][7'h7e], 8'h33);
    u_host.spi_sel(1'b1);
    u_host.spi_byte({7'h7c, 1'b1}, rx);
    for (int k = 0; k < 3; k++) begin
      u_host.spi_byte(8'h00, d);
      check(d, 8'h31 + k[7:0]);
    end
    u_host.spi_sel(1'b0);
    spi_write(PAGE_SEL_ADDR, 8'h00);
    // Two-wire mode: each strap setting, wrong address refused first
    protocol_select = 1'b0;
    for (int s = 0; s < 4; s++) begin
      {strap_b, strap_a} = s[1:0];
      u_host.wait_clk(8);
      u_host.i2c_start();
      i2c_tx({5'h06, ~s[1:0], 1'b0}, 1'b0);
      u_host.i2c_stop();
      u_host.i2c_start();
      i2c_tx({5'h06, s[1:0], 1'b0}, 1'b1);
      i2c_tx(8'h20 + s[7:0], 1'b1);
      i2c_tx(8'h50 + s[7:0], 1'b1);
      u_host.i2c_stop();
      check(mem[0][7'h20 + s[6:0]], 8'h50 + s[7:0]);
    end
    u_host.i2c_start();
    i2c_tx({5'h06, 2'h3, 1'b0}, 1'b1);
    i2c_tx(8'h30, 1'b1);
    i2c_tx(8'h61, 1'b1);
    i2c_tx(8'h62, 1'b1);
    u_host.i2c_stop();
    check(mem[0][7'h31], 8'h62);
    // Pointer write, repeated start, read two with ack then nack
    u_host.i2c_start();
    i2c_tx({5'h06, 2'h3, 1'b0}, 1'b1);
    i2c_tx(8'h30, 1'b1);
    u_host.i2c_start();
    i2c_tx({5'h06, 2'h3, 1'b1}, 1'b1);
    u_host.i2c_byte(8'hff, 1'b1, d, ack);
    check(d, 8'h61);
    u_host.i2c_byte(8'hff, 1'b0, d, ack);
    check(d, 8'h62);
    u_host.i2c_stop();
    // General call selects page 1
    u_host.i2c_start();
    i2c_tx(8'h00, 1'b1);
    i2c_tx(8'h00, 1'b1);
    i2c_tx(8'h01, 1'b1);
    u_host.i2c_stop();
    check({7'h00, page_select}, 8'h01);
    // Reset mid-run: page falls back to 0 and reads so over two-wire
    resetn = 1'b0;
    repeat (3) @(negedge clk);
    check({4'h0, page_select, reg_wr, miso_oe, sda_oe}, 8'h00);
    resetn = 1'b1;
    u_host.wait_clk(6);
    u_host.i2c_start();
    i2c_tx({5'h06, 2'h3, 1'b0}, 1'b1);
    i2c_tx(8'h00, 1'b1);
    u_host.i2c_start();
    i2c_tx({5'h06, 2'h3, 1'b1}, 1'b1);
    u_host.i2c_byte(8'hff, 1'b0, d, ack);
    check(d, 8'h00);
    u_host.i2c_stop();
    complete_run();
  end
endmodule : tb
`default_nettype wire
